// [verilog/two_wire_bit_if.v]
// Bit-level two-wire bus interface with flag handshaking, reached over AXI4-Lite.
// Assumes open-drain pads outside: an enable high pulls the line low.
//
// Overview of operation
// - Attention is high exactly when data-ready, arbitration-lost, start or stop is set.
// - Each clock rise captures data and sets data-ready unless idle slave; data access clears.
// - With arbitration, start or stop flag set, clearing data-ready does not release clock.
// - Arbitration loss only while transmitting; it clears transmit-active.
// - Sent one or repeated start but data sampled low: arbitration lost.
// - Sent one, another made repeated start: arbitration lost plus start seen.
// - Our repeated start beaten by clock pulled low first: arbitration lost.
// - Stop cannot form because another sends zero: arbitration lost.
// - Start sets start flag at master or active slave, not idle slave; the code does not set it for a start it drives itself.
// - Stop sets stop flag at master or active slave, not idle slave.
// - Master flag set when master request high and bus free.
// - Master flag cleared by arbitration loss, or by a stop request written while master request is low.
// - Data write or start/stop request sets transmit-active; data read or clear bit clears.
// - Data line pulled low only while transmit-active.
// - Idle bit makes slave ignore bus until next start.
// - Writing one to a clear bit clears its flag; zero leaves it.
// - Any attention flag stretches the clock low period.
// - Repeated start releases data in low, pulls it low after minimum high time.
// - Initial start of a frame is generated automatically.
// - Stop pulls data low in low phase, releases it after minimum high time.
// - Transmit bit reaches data line only while clock is low.
// - Timer preloaded with 8 minus minimum count at each clock change.
// - Timer counts machine cycles of six clocks.
// - Select codes 10,01,00,11 give 7,6,5,4 cycles and matching timeouts.
// - Timer overflow in a frame resets the interface and releases the clock; the code clears master, busy and transmit-active but keeps the flags.
//
// The register offsets and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
`include "twi_defs.vh"

module two_wire_bit_if (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // AXI4-Lite write channels
    input wire [`ADDR_W-1:0] awaddr,
    input wire awvalid,
    output reg awready,
    input wire [31:0] wdata,
    input wire [3:0] wstrb,
    input wire wvalid,
    output reg wready,
    output reg [1:0] bresp,
    output reg bvalid,
    input wire bready,
    // AXI4-Lite read channels
    input wire [`ADDR_W-1:0] araddr,
    input wire arvalid,
    output reg arready,
    output reg [31:0] rdata,
    output reg [1:0] rresp,
    output reg rvalid,
    input wire rready,
    // Bus clock line
    input wire scl_i,
    output reg scl_o,
    output reg scl_oe,
    // Bus data line
    input wire sda_i,
    output reg sda_o,
    output reg sda_oe
);
    // ------------------------------------------------------------------------
    // Master sequencer states
    // ------------------------------------------------------------------------
    localparam M_IDLE = 3'h0;
    localparam M_START = 3'h1;
    localparam M_LOW = 3'h2;
    localparam M_HIGH = 3'h3;
    localparam M_STOP = 3'h4;
    localparam P_NONE = 2'h0;
    localparam P_RSTART = 2'h1;
    localparam P_STOP = 2'h2;

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    wire scl_s, scl_rise, scl_fall;
    wire sda_s, sda_rise, sda_fall;
    wire min_done, timeout;
    reg data_ready_flag, arbitration_lost_flag, start_seen_flag, stop_seen_flag;
    reg receive_bit, transmit_bit, transmit_active, master, busy, slave_idle;
    reg slave_enable, master_request, bus_timer_run, timeout_seen;
    reg timing_select_high, timing_select_low;
    reg [2:0] state;
    reg [1:0] pending;
    reg next_arl;
    wire attention_flag, start_det, stop_det, active, wr_go, rd_go;
    wire wr_ctrl, wr_data, wr_cfg, rd_data;
    wire [7:0] wbyte;

    // ------------------------------------------------------------------------
    // Pin synchronisers and bus conditions
    // ------------------------------------------------------------------------
    pin_sync u_scl_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin(scl_i),
        .level(scl_s),
        .rise(scl_rise),
        .fall(scl_fall)
    );

    pin_sync u_sda_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin(sda_i),
        .level(sda_s),
        .rise(sda_rise),
        .fall(sda_fall)
    );

    assign start_det = sda_fall & scl_s;
    assign stop_det = sda_rise & scl_s;
    assign active = master | (slave_enable & ~slave_idle);
    assign attention_flag = data_ready_flag | arbitration_lost_flag |
        start_seen_flag | stop_seen_flag;

    bus_timer u_timer (
        .aclk(aclk),
        .aresetn(aresetn),
        .restart(scl_rise | scl_fall | start_det | stop_det),
        .frame_run(busy & bus_timer_run & (slave_enable | master_request | master)),
        .timing_sel({timing_select_high, timing_select_low}),
        .min_done(min_done),
        .timeout(timeout)
    );

    // ------------------------------------------------------------------------
    // AXI4-Lite slave: address and data taken together, one of each at a time
    // ------------------------------------------------------------------------
    assign wr_go = awvalid & awready & wvalid & wready;
    assign rd_go = arvalid & arready;
    assign wbyte = wstrb[0] ? wdata[7:0] : `REG_RESET;
    assign wr_ctrl = wr_go & wstrb[0] & (awaddr == `REG_CONTROL_STATUS);
    assign wr_data = wr_go & wstrb[0] & (awaddr == `REG_BIT_DATA);
    assign wr_cfg = wr_go & wstrb[0] & (awaddr == `REG_CONFIGURATION);
    assign rd_data = rd_go & (araddr == `REG_BIT_DATA);

    always @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= `RESP_OKAY;
            arready <= 1'b0;
            rvalid <= 1'b0;
            rresp <= `RESP_OKAY;
            rdata <= 32'h00000000;
        end else begin
            awready <= awvalid & wvalid & ~awready & ~bvalid;
            wready <= awvalid & wvalid & ~wready & ~bvalid;
            if (wr_go) begin
                bvalid <= 1'b1;
                case (awaddr)
                    `REG_CONTROL_STATUS, `REG_BIT_DATA, `REG_CONFIGURATION:
                        bresp <= `RESP_OKAY;
                    default: bresp <= `RESP_DECERR;
                endcase
            end else if (bready) begin
                bvalid <= 1'b0;
            end
            arready <= arvalid & ~arready & ~rvalid;
            if (rd_go) begin
                rvalid <= 1'b1;
                rresp <= `RESP_OKAY;
                case (araddr)
                    `REG_CONTROL_STATUS: rdata <= {24'h000000, receive_bit, attention_flag,
                        data_ready_flag, arbitration_lost_flag, start_seen_flag,
                        stop_seen_flag, master, transmit_active};
                    `REG_BIT_DATA: rdata <= {24'h000000, receive_bit, 7'h00};
                    `REG_CONFIGURATION: rdata <= {24'h000000, slave_enable,
                        master_request, timeout_seen, bus_timer_run, 2'h0,
                        timing_select_high, timing_select_low};
                    default: begin
                        rdata <= 32'h00000000;
                        rresp <= `RESP_DECERR;
                    end
                endcase
            end else if (rready) begin
                rvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Arbitration loss detection
    // ------------------------------------------------------------------------
    always @* begin
        next_arl = 1'b0;
        if (transmit_active) begin
            // We released data (sent one or a repeated start) yet it reads low
            if (scl_rise & ~sda_oe & ~sda_s)
                next_arl = 1'b1;
            // Another party made a repeated start over our one
            if (start_det & ~sda_oe & state != M_START)
                next_arl = 1'b1;
            if (state == M_HIGH & pending == P_RSTART & scl_fall)
                next_arl = 1'b1;
            if (state == M_STOP & scl_fall & ~sda_s & ~sda_oe)
                next_arl = 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // Status flags, transmit state and configuration
    // ------------------------------------------------------------------------
    // Clears come first so a hardware set in the same cycle wins.
    always @(posedge aclk) begin
        if (!aresetn) begin
            data_ready_flag <= 1'b0;
            arbitration_lost_flag <= 1'b0;
            start_seen_flag <= 1'b0;
            stop_seen_flag <= 1'b0;
            receive_bit <= 1'b1;
            transmit_bit <= 1'b1;
            transmit_active <= 1'b0;
            pending <= P_NONE;
            master <= 1'b0;
            busy <= 1'b0;
            slave_idle <= 1'b0;
            slave_enable <= 1'b0;
            master_request <= 1'b0;
            bus_timer_run <= 1'b0;
            timeout_seen <= 1'b0;
            timing_select_high <= 1'b0;
            timing_select_low <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                if (wbyte[`CW_CLEAR_DATA_READY_FLAG]) data_ready_flag <= 1'b0;
                if (wbyte[`CW_CLEAR_ARL]) arbitration_lost_flag <= 1'b0;
                if (wbyte[`CW_CLEAR_START]) start_seen_flag <= 1'b0;
                if (wbyte[`CW_CLEAR_STOP]) stop_seen_flag <= 1'b0;
                if (wbyte[`CW_CLEAR_XMIT]) transmit_active <= 1'b0;
                if (wbyte[`CW_IDLE]) slave_idle <= 1'b1;
                if (wbyte[`CW_SEND_RSTART]) begin
                    transmit_active <= 1'b1;
                    transmit_bit <= 1'b1;
                    pending <= P_RSTART;
                end
                if (wbyte[`CW_SEND_STOP]) begin
                    transmit_active <= 1'b1;
                    transmit_bit <= 1'b0;
                    pending <= P_STOP;
                    if (!master_request) master <= 1'b0;
                end
            end
            if (wr_data) begin
                transmit_bit <= wbyte[`DATA_BIT];
                transmit_active <= 1'b1;
                data_ready_flag <= 1'b0;
            end
            if (rd_data) begin
                transmit_active <= 1'b0;
                data_ready_flag <= 1'b0;
            end
            if (wr_cfg) begin
                slave_enable <= wbyte[`CFG_SLAVE_EN];
                master_request <= wbyte[`CFG_MASTER_REQ];
                bus_timer_run <= wbyte[`CFG_TIMER_RUN];
                timing_select_high <= wbyte[`CFG_SEL_HIGH];
                timing_select_low <= wbyte[`CFG_SEL_LOW];
                timeout_seen <= 1'b0;
            end
            if (scl_rise) begin
                receive_bit <= sda_s;
                if (active) data_ready_flag <= 1'b1;
            end
            if (start_det) begin
                busy <= 1'b1;
                // Our own start is not reported; an idle slave just wakes
                if (active & ~sda_oe) start_seen_flag <= 1'b1;
                slave_idle <= 1'b0;
            end
            if (stop_det) begin
                busy <= 1'b0;
                if (active) stop_seen_flag <= 1'b1;
            end
            if (master_request & ~busy & ~stop_det & ~start_det)
                master <= 1'b1;
            // Outside a frame a start or stop request has nothing to act on
            if (~busy | (state == M_START & min_done) | (state == M_STOP & stop_det))
                pending <= P_NONE;
            if (next_arl) begin
                arbitration_lost_flag <= 1'b1;
                master <= 1'b0;
                pending <= P_NONE;
            end
            if (next_arl | arbitration_lost_flag)
                transmit_active <= 1'b0;
            if (timeout) begin
                // Hang recovery: drop the frame and release the lines
                transmit_active <= 1'b0;
                master <= 1'b0;
                busy <= 1'b0;
                pending <= P_NONE;
                timeout_seen <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Line drivers and master sequencer
    // ------------------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            state <= M_IDLE;
            scl_o <= 1'b0;
            sda_o <= 1'b0;
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
        end else begin
            // Data only changes in the low phase, so an early write is safe
            if (!scl_s & state != M_START & state != M_STOP)
                sda_oe <= transmit_active & ~transmit_bit;
            case (state)
                M_IDLE: begin
                    // Slave side only stretches while attention is pending
                    scl_oe <= ~scl_s & active & attention_flag;
                    if (master & transmit_active & ~busy & scl_s & sda_s &
                            min_done & pending == P_NONE) begin
                        sda_oe <= 1'b1;
                        state <= M_START;
                    end
                end
                M_START: begin
                    if (~sda_s & min_done & ~start_det) begin
                        scl_oe <= 1'b1;
                        state <= M_LOW;
                    end
                end
                M_LOW: begin
                    // Attention holds the clock low until software clears it or the bus timer overflows
                    if (~scl_s & min_done & ~attention_flag & ~scl_fall) begin
                        scl_oe <= 1'b0;
                        state <= M_HIGH;
                    end
                end
                M_HIGH: begin
                    if (scl_fall) begin
                        scl_oe <= 1'b1;
                        state <= M_LOW;
                    end else if (scl_s & min_done & ~scl_rise) begin
                        case (pending)
                            P_RSTART: begin
                                sda_oe <= 1'b1;
                                state <= M_START;
                            end
                            P_STOP: begin
                                sda_oe <= 1'b0;
                                state <= M_STOP;
                            end
                            default: begin
                                scl_oe <= 1'b1;
                                state <= M_LOW;
                            end
                        endcase
                    end
                end
                M_STOP: begin
                    if (stop_det) state <= M_IDLE;
                end
                default: state <= M_IDLE;
            endcase
            if (next_arl | timeout) begin
                scl_oe <= 1'b0;
                sda_oe <= 1'b0;
                state <= M_IDLE;
            end
        end
    end
endmodule // two_wire_bit_if

// [verilog/twi_defs.vh]
// Constants for the bit-level two-wire bus interface: register map, bit fields,
// timer figures and AXI4-Lite answers. Included by every design file of the block.
`ifndef TWI_DEFS_VH
`define TWI_DEFS_VH

// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define ADDR_W 8
`define REG_CONTROL_STATUS 8'h00
`define REG_BIT_DATA 8'h04
`define REG_CONFIGURATION 8'h08

// ----------------------------------------------------------------------------
// bus_control_status, write side
// ----------------------------------------------------------------------------
`define CW_CLEAR_XMIT 7
`define CW_IDLE 6
`define CW_CLEAR_DATA_READY_FLAG 5
`define CW_CLEAR_ARL 4
`define CW_CLEAR_START 3
`define CW_CLEAR_STOP 2
`define CW_SEND_RSTART 1
`define CW_SEND_STOP 0

// ----------------------------------------------------------------------------
// bus_control_status, read side
// ----------------------------------------------------------------------------
`define CR_RECV_BIT 7
`define CR_ATTENTION 6
`define CR_DATA_READY_FLAG 5
`define CR_ARL 4
`define CR_START 3
`define CR_STOP 2
`define CR_MASTER 1
`define CR_XMIT_ACTIVE 0

// ----------------------------------------------------------------------------
// bus_bit_data and bus_configuration
// ----------------------------------------------------------------------------
`define DATA_BIT 7
`define CFG_SLAVE_EN 7
`define CFG_MASTER_REQ 6
`define CFG_TIMEOUT_SEEN 5
`define CFG_TIMER_RUN 4
`define CFG_SEL_HIGH 1
`define CFG_SEL_LOW 0
`define REG_RESET 8'h00

// ----------------------------------------------------------------------------
// Bus timer: machine cycle of 6 clocks, minimum time reached at count 008
// ----------------------------------------------------------------------------
`define MC_LAST 3'h5
`define TMR_DONE 10'h008
`define TMR_LAST 10'h3ff
`define MIN_SEL_10 3'h7
`define MIN_SEL_01 3'h6
`define MIN_SEL_00 3'h5
`define MIN_SEL_11 3'h4

// ----------------------------------------------------------------------------
// AXI4-Lite responses
// ----------------------------------------------------------------------------
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3

`endif

// [verilog/pin_sync.v]
// Two-stage synchroniser for one bus pin, with edge pulses taken after it.
// Assumes the pin is asynchronous to aclk.
`timescale 1ns/1ps
`include "twi_defs.vh"

module pin_sync (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Pin and synchronised view
    input wire pin,
    output wire level,
    output wire rise,
    output wire fall
);
    reg meta;
    reg stable;
    reg last;

    // Reset to the released (high) bus level
    always @(posedge aclk) begin
        if (!aresetn) begin
            meta <= 1'b1;
            stable <= 1'b1;
            last <= 1'b1;
        end else begin
            meta <= pin;
            stable <= meta;
            last <= stable;
        end
    end

    assign level = stable;
    assign rise = stable & ~last;
    assign fall = ~stable & last;
endmodule // pin_sync

// [verilog/bus_timer.v]
// Bus timer: machine-cycle prescaler and 10-bit counter for minimum times and
// frame-hang timeout. Assumes restart is a one-cycle pulse on any clock-line change.
`timescale 1ns/1ps
`include "twi_defs.vh"

module bus_timer (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Control
    input wire restart,
    input wire frame_run,
    input wire [1:0] timing_sel,
    // Status
    output wire min_done,
    output reg timeout
);
    reg [2:0] prescale;
    reg [9:0] count;
    wire tick;
    wire [9:0] preload;

    function [2:0] min_count;
        input [1:0] sel;
        begin
            case (sel)
                2'h2: min_count = `MIN_SEL_10;
                2'h1: min_count = `MIN_SEL_01;
                2'h0: min_count = `MIN_SEL_00;
                default: min_count = `MIN_SEL_11;
            endcase
        end
    endfunction

    assign tick = (prescale == `MC_LAST);
    assign preload = `TMR_DONE - {7'h00, min_count(timing_sel)};
    assign min_done = (count >= `TMR_DONE);

    always @(posedge aclk) begin
        if (!aresetn) begin
            prescale <= 3'h0;
            count <= `TMR_DONE;
            timeout <= 1'b0;
        end else begin
            timeout <= 1'b0;
            prescale <= tick ? 3'h0 : prescale + 3'h1;
            if (restart) begin
                prescale <= 3'h0;
                count <= preload;
            end else if (tick) begin
                // Only the low bits run outside a frame or with the timer disabled
                if (count < `TMR_DONE) begin
                    count <= count + 10'h001;
                end else if (frame_run) begin
                    if (count == `TMR_LAST) begin
                        timeout <= 1'b1;
                        count <= preload;
                    end else begin
                        count <= count + 10'h001;
                    end
                end
            end
        end
    end
endmodule // bus_timer

// [sim/twi_props.sv]
// Port assertions for the two-wire interface: register handshakes and line timing.
// Assumes it is bound to the interface's top module and sees only its ports.
`timescale 1ns/1ps
module twi_props (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Register bus
    input wire awready,
    input wire wready,
    input wire bvalid,
    input wire bready,
    input wire [1:0] bresp,
    input wire arready,
    input wire rvalid,
    input wire rready,
    input wire [31:0] rdata,
    // Bus lines
    input wire scl_o,
    input wire scl_oe,
    input wire sda_o,
    input wire sda_oe
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    reset_lines_a: assert property ($rose(aresetn) |-> !scl_oe && !sda_oe)
        else $error("line pulled after reset");
    pull_only_a: assert property (!scl_o && !sda_o)
        else $error("line driven high");
    write_answer_a: assert property (awready |-> wready ##1 bvalid)
        else $error("write not answered");
    bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write answer dropped");
    read_answer_a: assert property (arready |=> rvalid && !arready)
        else $error("read not answered");
    rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read answer dropped");
    rdata_upper_a: assert property (rvalid |-> rdata[31:8] == 24'h0)
        else $error("upper read bits set");
    low_min_a: assert property ($rose(scl_oe) |=> scl_oe [*8])
        else $error("clock low too short");
    high_min_a: assert property ($fell(scl_oe) |=> !scl_oe [*8])
        else $error("clock high too short");
    cover property ($rose(scl_oe));
    cover property ($rose(sda_oe));
    cover property (bvalid && bready);
endmodule // twi_props

bind two_wire_bit_if twi_props u_twi_props (.aclk, .aresetn, .awready, .wready, .bvalid,
    .bready, .bresp, .arready, .rvalid, .rready, .rdata, .scl_o, .scl_oe, .sda_o, .sda_oe);

// [sim/bus_node_model.sv]
// Slave on the two-wire bus: acknowledges the ninth bit and may stretch the clock.
// Assumes open-drain lines whose pull-ups the bench resolves.
`timescale 1ns/1ps
module bus_node_model (
    // Resolved lines
    input wire scl,
    input wire sda,
    // Stretch length in ns, 0 answers promptly
    input wire [7:0] stretch_ns,
    // Pull-downs
    output reg scl_pull,
    output reg sda_pull
);
    integer bits = 0;
    initial scl_pull = 0;
    initial sda_pull = 0;
    // A start restarts the count
    always @(negedge sda) if (scl) bits = 0;
    // Data moves only while the clock is low
    always @(negedge scl) begin
        bits = bits + 1;
        sda_pull = (bits == 9);
        scl_pull = (stretch_ns != 0);
        #(stretch_ns) scl_pull = 0;
    end
endmodule // bus_node_model

// [sim/tb_top.sv]
// Self-checking bench: register access, a master frame, and a lost arbitration.
// Assumes the design files and twi_defs.vh are compiled alongside.
`timescale 1ns/1ps
`include "twi_defs.vh"
module tb_top;
    reg aclk = 0;
    reg aresetn = 0;
    reg [7:0] awaddr = 0, araddr = 0, stretch = 0;
    reg [31:0] wdata = 0, v;
    reg awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, b;
    reg [1:0] sel;
    wire awready, wready, bvalid, arready, rvalid, scl_o, scl_oe, sda_o, sda_oe;
    wire scl_pull, sda_pull;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire scl = ~(scl_oe | scl_pull);
    wire sda = ~(sda_oe | sda_pull);
    integer n_fail = 0, samples_checked = 0, cycles = 0, i;
    always #2.5 aclk = ~aclk;
    two_wire_bit_if u_two_wire_bit_if (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
        .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
        .rdata, .rresp, .rvalid, .rready, .scl_i(scl), .scl_o, .scl_oe, .sda_i(sda), .sda_o,
        .sda_oe);
    bus_node_model u_bus_node_model (.scl, .sda, .stretch_ns(stretch), .scl_pull, .sda_pull);
    task finish_test; begin
        $display("checks %0d failures %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    end endtask
    task chk(input [31:0] got, input [31:0] exp); begin
        samples_checked = samples_checked + 1;
        if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
        end
    end endtask
    task wr(input [7:0] a, input [7:0] d); begin
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        do @(posedge aclk); while (!awready);
        awvalid <= 0;
        wvalid <= 0;
        do @(posedge aclk); while (!bvalid);
        bready <= 0;
        chk(bresp, (a > `REG_CONFIGURATION) ? `RESP_DECERR : `RESP_OKAY);
    end endtask
    // Response code rides in the two top bits, which read data never uses
    task rd(input [7:0] a); begin
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do @(posedge aclk); while (!arready);
        arvalid <= 0;
        do @(posedge aclk); while (!rvalid);
        rready <= 0;
        v = {rresp, rdata[29:0]};
    end endtask
    function [31:0] cs(input rb, input dr, input al, input ms, input xa);
        cs = {24'h0, rb, dr | al, dr, al, 2'b00, ms, xa};
    endfunction
    always @(posedge aclk) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            n_fail = n_fail + 1;
            finish_test;
        end
    end
    initial begin
        void'($urandom(32'h8c8f1f4a));
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        // Receive bit idles at the released line level until the first clock rise
        rd(`REG_CONTROL_STATUS);
        chk(v, cs(1, 0, 0, 0, 0));
        rd(`REG_CONFIGURATION);
        chk(v, 32'h0);
        rd(8'h0c);
        chk(v, {`RESP_DECERR, 30'h0});
        wr(8'h0c, 8'hff);
        wr(`REG_BIT_DATA, 8'h80);
        wr(`REG_CONTROL_STATUS, 8'h3c);
        rd(`REG_CONTROL_STATUS);
        chk(v, cs(1, 0, 0, 0, 1));
        wr(`REG_CONTROL_STATUS, 8'h80);
        rd(`REG_CONTROL_STATUS);
        chk(v, cs(1, 0, 0, 0, 0));
        wr(`REG_CONTROL_STATUS, 8'h02);
        rd(`REG_BIT_DATA);
        chk(v, 32'h80);
        rd(`REG_CONTROL_STATUS);
        chk(v, cs(1, 0, 0, 0, 0));
        sel = $urandom % 4;
        wr(`REG_CONFIGURATION, {6'h34, sel});
        rd(`REG_CONFIGURATION);
        chk(v, {24'h0, 6'h34, sel});
        rd(`REG_CONTROL_STATUS);
        chk(v, cs(1, 0, 0, 1, 0));
        // Ninth bit sends a one against the slave's acknowledge
        for (i = 0; i < 9; i = i + 1) begin
            b = (i < 8) ? ($urandom % 2) : 1'b1;
            stretch <= (i > 4) ? 8'd80 : 8'd0;
            wr(`REG_BIT_DATA, {b, 7'h0});
            do rd(`REG_CONTROL_STATUS); while (!v[5]);
            chk(v, (i < 8) ? cs(b, 1, 0, 1, 1) : cs(0, 1, 1, 0, 0));
        end
        wr(`REG_CONTROL_STATUS, 8'h20);
        rd(`REG_CONTROL_STATUS);
        chk(v, cs(0, 0, 1, 0, 0));
        wr(`REG_CONTROL_STATUS, 8'h10);
        rd(`REG_CONTROL_STATUS);
        chk(v, cs(0, 0, 0, 0, 0));
        finish_test;
    end
endmodule // tb_top
